// *** sync_clamp_coast_control.sv ***
/*
  Sync, clamp and coast control register group of a triple-channel video
  digitizer, with the sync routing that these registers steer.
  Assumes the serial port decoder delivers byte writes and reads on clk_sys,
  and that sync detectors and the slicer supply presence/polarity levels.
*/
`timescale 1ns/1ps
module sync_clamp_coast_control
  import sync_clamp_coast_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Register port from the serial decoder
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Sync and control pins, asynchronous
  input  wire logic       hsync_pin,
  input  wire logic       sog_sync,
  input  wire logic       vsync_pin,
  input  wire logic       sep_vsync,
  input  wire logic       clamp_pin,
  input  wire logic       coast_pin,
  // Detector levels, asynchronous
  input  wire logic       hsync_present,
  input  wire logic       sog_present,
  input  wire logic       hsync_pol_detect,
  input  wire logic       coast_pol_detect,
  // Processed sync outputs
  output logic            pll_hsync,
  output logic            hsync_out,
  output logic            vsync_out,
  output logic            clamp_out,
  output logic            pll_coast,
  // Mode outputs
  output logic            seek_low_power_allow,
  output logic            full_chip_power_down_n,
  output logic      [4:0] sog_threshold,
  output logic      [7:0] green_offset,
  output logic      [7:0] blue_offset,
  // Status outputs
  output logic            auto_hsync_source_status,
  output logic            auto_vsync_source_status
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 10;

  logic [NSYNC-1:0] sync_meta;
  logic [NSYNC-1:0] sync_q;

  // Two flops for every asynchronous input
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sync_meta <= '0;
      sync_q    <= '0;
    end else begin
      sync_meta <= {hsync_pin, sog_sync, vsync_pin, sep_vsync, clamp_pin,
                    coast_pin, hsync_present, sog_present, hsync_pol_detect,
                    coast_pol_detect};
      sync_q    <= sync_meta;
    end
  end

  wire hs_pin_s  = sync_q[9];
  wire sog_s     = sync_q[8];
  wire vs_pin_s  = sync_q[7];
  wire sep_vs_s  = sync_q[6];
  wire clamp_s   = sync_q[5];
  wire coast_s   = sync_q[4];
  wire hs_pres_s = sync_q[3];
  wire sog_pres_s = sync_q[2];
  wire hs_pol_s  = sync_q[1];
  wire co_pol_s  = sync_q[0];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] green_offset_reg;
  logic [7:0] blue_offset_reg;
  logic [7:0] sync_control_reg;
  logic [7:0] clamp_coast_power_control_reg;
  logic [7:0] green_sync_slicer_threshold_reg;

  // Write decode
  wire wr_green  = reg_wr_en && (reg_addr == ADDR_GREEN_OFFSET);
  wire wr_blue   = reg_wr_en && (reg_addr == ADDR_BLUE_OFFSET);
  wire wr_sync   = reg_wr_en && (reg_addr == ADDR_SYNC_CONTROL);
  wire wr_clamp  = reg_wr_en && (reg_addr == ADDR_CLAMP_COAST);
  wire wr_thresh = reg_wr_en && (reg_addr == ADDR_SOG_THRESH);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      green_offset_reg                <= RST_OFFSET;
      blue_offset_reg                 <= RST_OFFSET;
      sync_control_reg                <= RST_SYNC;
      clamp_coast_power_control_reg   <= RST_CLAMP_COAST;
      green_sync_slicer_threshold_reg <= RST_SOG_THRESH;
    end else begin
      if (wr_green)  green_offset_reg <= reg_wdata & MASK_OFFSET;
      if (wr_blue)   blue_offset_reg  <= reg_wdata & MASK_OFFSET;
      if (wr_sync)   sync_control_reg <= reg_wdata & MASK_SYNC;
      if (wr_clamp)  clamp_coast_power_control_reg <= reg_wdata & MASK_CLAMP_COAST;
      if (wr_thresh) green_sync_slicer_threshold_reg <= reg_wdata & MASK_SOG_THRESH;
    end
  end

  // Read selection, unmapped addresses read zero
  // register readback
  wire [7:0] rdata_next =
    (reg_addr == ADDR_GREEN_OFFSET) ? green_offset_reg :
    (reg_addr == ADDR_BLUE_OFFSET)  ? blue_offset_reg :
    (reg_addr == ADDR_SYNC_CONTROL) ? sync_control_reg :
    (reg_addr == ADDR_CLAMP_COAST)  ? clamp_coast_power_control_reg :
    (reg_addr == ADDR_SOG_THRESH)   ? green_sync_slicer_threshold_reg :
                                      READ_ZERO;

  // ----------------------------------------------------------------
  // Hsync source and polarity
  // ----------------------------------------------------------------
  wire [7:0] sc = sync_control_reg;
  wire [7:0] cc = clamp_coast_power_control_reg;

  // Normalise a sync level to active high; pol 1 means already active high.
  // Shared by the hsync and coast paths so both read polarity alike.
  function automatic logic to_active_high(input logic lvl, input logic pol);
    return lvl ^ ~pol;
  endfunction

  // select bit breaks the tie when both present
  wire auto_hs_next = (hs_pres_s && sog_pres_s) ? sc[SC_HSRC_SEL] :
                      (sog_pres_s && !hs_pres_s);

  wire hs_src   = sc[SC_HSRC_OVR] ? sc[SC_HSRC_SEL] : auto_hs_next;
  wire hs_raw   = hs_src ? sog_s : hs_pin_s;

  wire hs_pol   = sc[SC_HPOL_OVR] ? sc[SC_HPOL] : hs_pol_s;
  wire hs_act   = to_active_high(hs_raw, hs_pol);

  // output polarity, 1 gives low pulse
  wire hs_out_next = hs_act ^ sc[SC_HOUT_POL];

  // ----------------------------------------------------------------
  // Vsync source and inversion
  // ----------------------------------------------------------------
  // automatic vsync follows sync-on-green use
  wire auto_vs_next = hs_src;

  wire vs_src   = sc[SC_VSRC_OVR] ? sc[SC_VSRC_SEL] : auto_vs_next;
  wire vs_sel   = vs_src ? sep_vs_s : vs_pin_s;

  wire vs_out_next = sc[SC_VOUT_NINV] ? vs_sel : ~vs_sel;

  // ----------------------------------------------------------------
  // Clamp and coast
  // ----------------------------------------------------------------
  // clamp source
  wire clamp_next = cc[CC_CLAMP_SRC] ? (clamp_s ^ cc[CC_CLAMP_POL]) : hs_act;

  wire coast_raw  = cc[CC_COAST_SRC] ? vs_sel : coast_s;

  wire coast_pol  = cc[CC_COAST_OVR] ? cc[CC_COAST_POL] : co_pol_s;
  wire coast_next = to_active_high(coast_raw, coast_pol);

  // ----------------------------------------------------------------
  // Output flops
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata                <= READ_ZERO;
      pll_hsync                <= 1'b0;
      hsync_out                <= 1'b0;
      vsync_out                <= 1'b0;
      clamp_out                <= 1'b0;
      pll_coast                <= 1'b0;
      seek_low_power_allow     <= RST_CLAMP_COAST[CC_SEEK_LOWP];
      full_chip_power_down_n   <= RST_CLAMP_COAST[CC_PWR_N];
      sog_threshold            <= RST_SOG_THRESH[TH_MSB:TH_LSB];
      green_offset             <= RST_OFFSET;
      blue_offset              <= RST_OFFSET;
      auto_hsync_source_status <= 1'b0;
      auto_vsync_source_status <= 1'b0;
    end else begin
      reg_rdata                <= rdata_next;
      pll_hsync                <= hs_act;
      hsync_out                <= hs_out_next;
      vsync_out                <= vs_out_next;
      clamp_out                <= clamp_next;
      pll_coast                <= coast_next;
      seek_low_power_allow     <= cc[CC_SEEK_LOWP];
      full_chip_power_down_n   <= cc[CC_PWR_N];
      sog_threshold            <= green_sync_slicer_threshold_reg[TH_MSB:TH_LSB];
      green_offset             <= green_offset_reg;
      blue_offset              <= blue_offset_reg;
      auto_hsync_source_status <= auto_hs_next;
      auto_vsync_source_status <= auto_vs_next;
    end
  end

endmodule

// *** sync_clamp_coast_pkg.sv ***
/*
  Constants for the sync, clamp and coast control register group:
  register addresses, field positions, writable masks and reset values.
  Assumes an 8-bit register address coming from the serial port decoder.
*/
package sync_clamp_coast_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GREEN_OFFSET = 8'h0c;
  localparam logic [7:0] ADDR_BLUE_OFFSET  = 8'h0d;
  localparam logic [7:0] ADDR_SYNC_CONTROL = 8'h0e;
  localparam logic [7:0] ADDR_CLAMP_COAST  = 8'h0f;
  localparam logic [7:0] ADDR_SOG_THRESH   = 8'h10;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_OFFSET      = 8'hfe;
  localparam logic [7:0] MASK_SYNC        = 8'hff;
  localparam logic [7:0] MASK_CLAMP_COAST = 8'hfe;
  localparam logic [7:0] MASK_SOG_THRESH  = 8'hf8;
  localparam logic [7:0] RST_OFFSET       = 8'h80;
  localparam logic [7:0] RST_SYNC         = 8'h00;
  localparam logic [7:0] RST_CLAMP_COAST  = 8'h4e;
  localparam logic [7:0] RST_SOG_THRESH   = 8'hb8;
  localparam logic [7:0] READ_ZERO        = 8'h00;

  // ----------------------------------------------------------------
  // Sync control fields
  // ----------------------------------------------------------------
  localparam int SC_HPOL_OVR  = 7;
  localparam int SC_HPOL      = 6;
  localparam int SC_HOUT_POL  = 5;
  localparam int SC_HSRC_OVR  = 4;
  localparam int SC_HSRC_SEL  = 3;
  localparam int SC_VOUT_NINV = 2;
  localparam int SC_VSRC_OVR  = 1;
  localparam int SC_VSRC_SEL  = 0;

  // ----------------------------------------------------------------
  // Clamp and coast fields
  // ----------------------------------------------------------------
  localparam int CC_CLAMP_SRC  = 7;
  localparam int CC_CLAMP_POL  = 6;
  localparam int CC_COAST_SRC  = 5;
  localparam int CC_COAST_OVR  = 4;
  localparam int CC_COAST_POL  = 3;
  localparam int CC_SEEK_LOWP  = 2;
  localparam int CC_PWR_N      = 1;

  // Slicer threshold field
  localparam int TH_MSB = 7;
  localparam int TH_LSB = 3;

endpackage

// *** sync_props.sv ***
/*
  Checker for the sync, clamp and coast register group.
  Assumes it is bound into the top module and sees only its ports.
*/
`timescale 1ns/1ps
module sync_props
  import sync_clamp_coast_pkg::*;
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // Register port
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Sync pins
  input wire logic       hsync_pin,
  input wire logic       sog_sync,
  input wire logic       vsync_pin,
  input wire logic       sep_vsync,
  input wire logic       clamp_pin,
  input wire logic       coast_pin,
  // Watched outputs
  input wire logic       pll_hsync,
  input wire logic       hsync_out,
  input wire logic       vsync_out,
  input wire logic       clamp_out,
  input wire logic       pll_coast,
  input wire logic       seek_low_power_allow,
  input wire logic       full_chip_power_down_n,
  input wire logic [4:0] sog_threshold,
  input wire logic [7:0] green_offset,
  input wire logic [7:0] blue_offset,
  // Detector pins and status
  input wire logic       hsync_present,
  input wire logic       sog_present,
  input wire logic       auto_hsync_source_status,
  input wire logic       auto_vsync_source_status
);
  logic [7:0] sc_reg;
  logic [7:0] cc_reg;
  logic [2:0] age_reg;
  // Mode writes and settle flag
  wire wr_sc   = reg_wr_en && reg_addr == ADDR_SYNC_CONTROL;
  wire wr_cc   = reg_wr_en && reg_addr == ADDR_CLAMP_COAST;
  wire settled = age_reg >= 3'h4;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Shadow of mode registers, cycles since last mode write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sc_reg  <= 8'h00;
      cc_reg  <= 8'h4e;
      age_reg <= 3'h0;
    end else begin
      if (wr_sc) sc_reg <= reg_wdata;
      if (wr_cc) cc_reg <= reg_wdata;
      age_reg <= (wr_sc || wr_cc) ? 3'h0 : 3'(age_reg + {2'h0, age_reg != 3'h7});
    end
  end
  sequence s_wr_cc; wr_cc; endsequence
  sequence s_rd_sc; wr_sc ##1 (!reg_wr_en && reg_addr == ADDR_SYNC_CONTROL); endsequence
  pwr_down_a: assert property (s_wr_cc |-> ##2
    full_chip_power_down_n == $past(reg_wdata[CC_PWR_N], 2)) else $error("power level");
  seek_allow_a: assert property (s_wr_cc |-> ##2
    seek_low_power_allow == $past(reg_wdata[CC_SEEK_LOWP], 2)) else $error("seek level");
  slicer_level_a: assert property (reg_wr_en && reg_addr == ADDR_SOG_THRESH |-> ##2
    sog_threshold == $past(reg_wdata[7:3], 2)) else $error("slicer level");
  offset_lsb_a: assert property (reg_wr_en && reg_addr == ADDR_GREEN_OFFSET |-> ##2
    green_offset == {$past(reg_wdata[7:1], 2), 1'b0}) else $error("offset value");
  blue_lsb_a: assert property (reg_wr_en && reg_addr == ADDR_BLUE_OFFSET |-> ##2
    blue_offset == {$past(reg_wdata[7:1], 2), 1'b0}) else $error("blue offset value");
  auto_hsync_a: assert property (settled |-> auto_hsync_source_status ==
    (($past(hsync_present, 3) && $past(sog_present, 3)) ? sc_reg[3] :
     ($past(sog_present, 3) && !$past(hsync_present, 3)))) else $error("auto hsync");
  auto_vsync_a: assert property (settled |-> auto_vsync_source_status ==
    (sc_reg[4] ? sc_reg[3] : auto_hsync_source_status)) else $error("auto vsync");
  unmapped_zero_a: assert property (!(reg_addr inside {[8'h0c:8'h10]}) |=>
    reg_rdata == 8'h00) else $error("unmapped read");
  sync_readback_a: assert property (s_rd_sc |=>
    reg_rdata == $past(reg_wdata, 2)) else $error("readback");
  hsync_pll_a: assert property (settled && sc_reg[7] && sc_reg[4] |->
    pll_hsync == ((sc_reg[3] ? $past(sog_sync, 3) : $past(hsync_pin, 3)) ^ !sc_reg[6]))
    else $error("pll hsync");
  hsync_pol_a: assert property (settled |-> hsync_out == (pll_hsync ^ sc_reg[5]))
    else $error("hsync out");
  vsync_sel_a: assert property (settled && sc_reg[1] |->
    vsync_out == ((sc_reg[0] ? $past(sep_vsync, 3) : $past(vsync_pin, 3)) ^ !sc_reg[2]))
    else $error("vsync out");
  clamp_ext_a: assert property (settled && cc_reg[7] |->
    clamp_out == ($past(clamp_pin, 3) ^ cc_reg[6])) else $error("clamp out");
  coast_pin_a: assert property (settled && !cc_reg[5] && cc_reg[4] |->
    pll_coast == ($past(coast_pin, 3) ^ !cc_reg[3])) else $error("coast out");
endmodule

bind sync_clamp_coast_control sync_props u_props (.*);

// *** ctl_model.sv ***
/*
  Controller model on the decoded register port.
  Assumes requests launch on the falling edge of clk_sys.
*/
`timescale 1ns/1ps
module ctl_model (
  // Clock and read data
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  // Register requests
  output logic            reg_wr_en = 1'b0,
  output logic      [7:0] reg_addr  = 8'h00,
  output logic      [7:0] reg_wdata = 8'h00
);
  logic [7:0] rd_data;
  int         rd_cnt = 0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    rd_data = reg_rdata;
    rd_cnt++;
  endtask
endmodule

// *** testbench.sv ***
/*
  Self-checking bench for the sync, clamp and coast register group.
  Assumes the controller model drives the port; pins get random levels.
*/
`timescale 1ns/1ps
module testbench
  import sync_clamp_coast_pkg::*;
;
  logic clk_sys = 1'b0, rst_b = 1'b0, reg_wr_en, pll_hsync, hsync_out, vsync_out;
  logic hsync_pin, sog_sync, vsync_pin, sep_vsync, clamp_pin, coast_pin, clamp_out;
  logic hsync_present, sog_present, hsync_pol_detect, coast_pol_detect, pll_coast;
  logic seek_low_power_allow, full_chip_power_down_n;
  logic auto_hsync_source_status, auto_vsync_source_status;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, green_offset, blue_offset, got_exp;
  logic [4:0] sog_threshold;
  logic [9:0] pins = 10'h000;
  logic [15:0] rnd = 16'hd632;
  logic [7:0] exp_q[$];
  int failures = 0, total_checks = 0;
  // Address, reset value, writable bits
  logic [7:0] tbl [5][3] = '{'{8'h0c, 8'h80, 8'hfe}, '{8'h0d, 8'h80, 8'hfe},
    '{8'h0e, 8'h00, 8'hff}, '{8'h0f, 8'h4e, 8'hfe}, '{8'h10, 8'hb8, 8'hf8}};
  assign {hsync_pin, sog_sync, vsync_pin, sep_vsync, clamp_pin} = pins[4:0];
  assign {coast_pin, hsync_present, sog_present, hsync_pol_detect, coast_pol_detect} = pins[9:5];
  always #2 clk_sys = ~clk_sys;
  sync_clamp_coast_control dut (.*);
  ctl_model ctl (.*);
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Random pin levels each falling edge
  always @(negedge clk_sys) begin
    rnd  <= lfsr(rnd);
    pins <= rnd[9:0];
  end
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    ctl.rd(a);
  endtask
  // Compare each returned read with the oldest note
  always @(ctl.rd_cnt) begin
    got_exp = exp_q.pop_front();
    total_checks++;
    if (ctl.rd_data !== got_exp) begin
      failures++;
      $display("CHECK FAILED reg_rdata expected %h seen %h", got_exp, ctl.rd_data);
    end
  end
  task automatic finish_test();
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Main sequence, run twice with a reset in between
  initial begin
    logic [15:0] d;
    for (int r = 0; r < 2; r++) begin
      rst_b = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_b = 1'b1;
      for (int i = 0; i < 5; i++) chk(tbl[i][0], tbl[i][1]);
      chk(8'h0b, 8'h00);
      chk(8'h11, 8'h00);
      for (int i = 0; i < 5; i++) begin
        ctl.wr(tbl[i][0], 8'hff);
        chk(tbl[i][0], tbl[i][2]);
        ctl.wr(tbl[i][0], 8'h00);
        chk(tbl[i][0], 8'h00);
      end
      for (int i = 0; i < 16; i++) begin
        d = rnd;
        ctl.wr(ADDR_SYNC_CONTROL, d[7:0]);
        chk(ADDR_SYNC_CONTROL, d[7:0]);
        ctl.wr(ADDR_CLAMP_COAST, d[15:8]);
        chk(ADDR_CLAMP_COAST, d[15:8] & 8'hfe);
        repeat (8) @(negedge clk_sys);
      end
    end
    @(negedge clk_sys);
    finish_test();
  end
  // Watchdog
  initial begin
    #100000;
    failures++;
    finish_test();
  end
endmodule
